// ### core/drpm_top.sv
// debug and reset pin function mux with its ahb-lite registers
//
// Overview of operation
// - debug data pin bidirectional, receive by default
// - debug clock pin always input in debug
// - clock on port1_bit8, data on port1_bit9
// - reset gives debug; bit 6 clear frees
// - 30 ms hold-off delays pin reuse
// - pull-ups forced on in debug function
// - gpio pull-ups from port1_pullup_enable bits
// - no debug access while pins reused
// - reset pin default; bit 5 makes gpio
// - execution held while reset pin low
// - reused reset pin never resets chip
// - debug unaffected by reset pin reuse
`timescale 1ns/1ps
`include "drpm_cfg.svh"

// ********************************************
// hold-off counter, low-speed oscillator domain
// ********************************************
module drpm_holdoff
	import drpm_pkg::*;
#(
	parameter int HOLD_CYC = 960
)(
	// oscillator clock and power-on reset
	input logic lrc_clk,
	input logic rst,
	// level, high once the hold-off is over
	output logic hold_done
);
	// counter state and its next value
	drpm_ho_t st_q;
	drpm_ho_t st_d;

	// count oscillator rising edges from release; the first
	// period may be partial, so one less than the count is
	// the floor, a slow oscillator only lengthens the hold
	always_comb
	begin
		st_d = st_q;
		if (!st_q.done)
		begin
			st_d.cnt = st_q.cnt + 16'h0001;
			if (st_q.cnt == 16'(HOLD_CYC - 1))
				st_d.done = 1'b1;
		end
	end

	// state register
	always_ff @(posedge lrc_clk or posedge rst)
	begin
		if (rst)
			st_q <= '{cnt: 16'h0000, done: 1'b0};
		else
			st_q <= st_d;
	end

	assign hold_done = st_q.done;

	// done rises only after exactly the nominal count
	hold_len_a: assert property (
		@(posedge lrc_clk) disable iff (rst)
		$rose(st_q.done) |-> $past(st_q.cnt) == 16'(HOLD_CYC - 1))
		else $error("hold-off ended at wrong count");
endmodule : drpm_holdoff

// ********************************************
// pin mux top, system clock domain
// ********************************************
module drpm_top
	import drpm_pkg::*;
#(
	parameter int LRC_HZ = `DRPM_LRC_HZ
)(
	// system clock and hard reset
	input logic sys_clk,
	input logic rst,
	// low-speed oscillator clock
	input logic low_speed_rc_osc,
	// ahb-lite slave
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// port1_bit8 pad, debug clock or gpio
	input logic port1_bit8_in,
	output drpm_pad_t port1_bit8_pad,
	// port1_bit9 pad, debug data or gpio
	input logic port1_bit9_in,
	output drpm_pad_t port1_bit9_pad,
	// port1 gpio block, index 0 is bit 8
	input logic [1:0] port1_gpio_out,
	input logic [1:0] port1_gpio_oe,
	output logic [1:0] port1_gpio_in,
	// debug port
	output logic dbg_swclk,
	output logic dbg_swdio_in,
	input logic dbg_swdio_out,
	input logic dbg_swdio_oe,
	output logic dbg_enable,
	// external_reset_pin pad, reset or port0_bit2
	input logic external_reset_pin_in,
	output drpm_pad_t external_reset_pad,
	input logic port0_bit2_out,
	input logic port0_bit2_oe,
	output logic port0_bit2_in,
	// reset request to the core, high holds it
	output logic ext_reset_req
);
	// hold-off length in oscillator periods, rounded up
	localparam int HOLD_CYC =
		(`DRPM_HOLD_MS * LRC_HZ + 999) / 1000;

	// all state and its next value
	drpm_st_t st_q;
	drpm_st_t st_d;
	// pins handed to gpio, effective
	logic dbg_gpio;
	// function of the debug pins
	drpm_mode_t mode;
	// hold-off done, oscillator domain
	logic hold_done;
	// address phase taken this cycle
	logic take;

	// ********************************************
	// hold-off counter
	// ********************************************
	drpm_holdoff #(
		.HOLD_CYC(HOLD_CYC)
	) u_hold (
		.lrc_clk(low_speed_rc_osc),
		.rst(rst),
		.hold_done(hold_done)
	);

	// a change counts once second and third stage agree
	function automatic logic agree(
		input logic [2:0] s,
		input logic cur
	);
		agree = (s[2] == s[1]) ? s[2] : cur;
	endfunction : agree

	// ********************************************
	// registers, synchronisers and bus
	// ********************************************
	assign take = hsel && htrans[1] && hready;

	// next state: write data phase first, then read
	// data from the updated copy so back-to-back
	// write then read sees the new value
	always_comb
	begin
		st_d = st_q;
		st_d.wp = 1'b0;
		// write data phase
		if (st_q.wp)
		begin
			case (st_q.wa)
				`DRPM_OFF_IOCFG:
				begin
					// a zero requests reuse, a one
					// restores debug at once
					st_d.dbg_en =
						hwdata[`DRPM_BIT_DBGEN];
					st_d.rst_io =
						hwdata[`DRPM_BIT_RSTIO];
				end
				`DRPM_OFF_PUE:
				begin
					st_d.pue = hwdata[`DRPM_BIT_PU9:
						`DRPM_BIT_PU8];
				end
				default:
				begin
					// unmapped or read-only: ignored
				end
			endcase
		end
		// oscillator level, three stages
		st_d.done_s = {st_q.done_s[1:0], hold_done};
		st_d.done_lvl = agree(st_q.done_s, st_q.done_lvl);
		// reset pin, three stages
		st_d.rpin_s = {st_q.rpin_s[1:0],
			external_reset_pin_in};
		st_d.rpin_lvl = agree(st_q.rpin_s, st_q.rpin_lvl);
		// hold the core while the pin is low, but only
		// while the pin keeps its reset function
		st_d.rst_req = !st_q.rst_io &&
			!st_q.rpin_lvl;
		// address phase
		if (take)
		begin
			st_d.wp = hwrite;
			st_d.wa = haddr[7:0];
			if (!hwrite)
			begin
				case (haddr[7:0])
					`DRPM_OFF_IOCFG:
					begin
						st_d.rdata = 32'h0000_0000;
						st_d.rdata[`DRPM_BIT_DBGEN] =
							st_d.dbg_en;
						st_d.rdata[`DRPM_BIT_RSTIO] =
							st_d.rst_io;
					end
					`DRPM_OFF_PUE:
					begin
						st_d.rdata = 32'h0000_0000;
						st_d.rdata[`DRPM_BIT_PU9:
							`DRPM_BIT_PU8] = st_d.pue;
					end
					`DRPM_OFF_STAT:
					begin
						st_d.rdata = {28'h000_0000,
							st_d.rpin_lvl, st_d.rst_io,
							!st_d.dbg_en && st_d.done_lvl,
							st_d.done_lvl};
					end
					default:
					begin
						st_d.rdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// state register; debug function after any hard
	// reset, core held until the pin is seen high
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '{
				dbg_en: `DRPM_RST_DBGEN,
				rst_io: `DRPM_RST_RSTIO,
				pue: `DRPM_RST_PUE,
				wp: 1'b0,
				wa: 8'h00,
				rdata: `DRPM_RST_RDATA,
				done_s: 3'h0,
				done_lvl: 1'b0,
				rpin_s: 3'h0,
				rpin_lvl: 1'b0,
				rst_req: 1'b1};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// zero-wait slave, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_q.rdata;
	assign ext_reset_req = st_q.rst_req;

	// ********************************************
	// pin function mux
	// ********************************************
	// a reuse written early waits for the hold-off
	assign dbg_gpio = !st_q.dbg_en && st_q.done_lvl;
	assign mode = dbg_gpio ? DRPM_GPIO : DRPM_DBG;

	// pads and debug inputs by function
	always_comb
	begin
		case (mode)
			DRPM_GPIO:
			begin
				// pull-ups under software control
				port1_bit8_pad = '{port1_gpio_out[0],
					port1_gpio_oe[0], st_q.pue[0]};
				port1_bit9_pad = '{port1_gpio_out[1],
					port1_gpio_oe[1], st_q.pue[1]};
				// debug port sees idle lines only
				dbg_swclk = 1'b0;
				dbg_swdio_in = 1'b1;
				dbg_enable = 1'b0;
			end
			default:
			begin
				// clock pin input only, pull-up forced
				port1_bit8_pad = '{1'b0, 1'b0,
					1'b1};
				// data pin direction from the debug port
				port1_bit9_pad = '{dbg_swdio_out,
					dbg_swdio_oe, 1'b1};
				dbg_swclk = port1_bit8_in;
				dbg_swdio_in = port1_bit9_in;
				// reset pin use plays no part here
				dbg_enable = 1'b1;
			end
		endcase
	end

	// gpio readback straight from the pads; the gpio
	// block synchronises them itself
	assign port1_gpio_in = {port1_bit9_in, port1_bit8_in};
	assign port0_bit2_in = external_reset_pin_in;

	// reset pad: 100k pull-up only as reset
	assign external_reset_pad = '{port0_bit2_out,
		st_q.rst_io && port0_bit2_oe,
		!st_q.rst_io};

	// ********************************************
	// checks
	// ********************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	swclk_input_a: assert property (
		!dbg_gpio |-> !port1_bit8_pad.oe &&
			dbg_swclk == port1_bit8_in)
		else $error("debug clock pin driven");
	swdio_dir_a: assert property (
		!dbg_gpio |-> port1_bit9_pad.oe == dbg_swdio_oe &&
			port1_bit9_pad.out == dbg_swdio_out)
		else $error("debug data direction wrong");
	dbg_pullup_a: assert property (
		!dbg_gpio |-> port1_bit8_pad.pu && port1_bit9_pad.pu)
		else $error("debug pull-up not forced");
	gpio_pullup_a: assert property (
		dbg_gpio |-> port1_bit8_pad.pu == st_q.pue[0] &&
			port1_bit9_pad.pu == st_q.pue[1])
		else $error("gpio pull-up not from register");
	hold_gate_a: assert property (
		!st_q.done_lvl |-> !dbg_gpio && dbg_enable)
		else $error("reuse active during hold-off");
	dbg_block_a: assert property (
		dbg_gpio |-> !dbg_enable && dbg_swdio_in)
		else $error("debug access while reused");
	restore_dbg_a: assert property (
		st_q.wp && st_q.wa == `DRPM_OFF_IOCFG &&
		hwdata[`DRPM_BIT_DBGEN] |=> !dbg_gpio && dbg_enable)
		else $error("debug not restored by write");
	reset_hold_a: assert property (
		!st_q.rst_io && !st_q.rpin_lvl |=> ext_reset_req)
		else $error("core released with pin low");
	reset_ignore_a: assert property (
		st_q.rst_io |=> !ext_reset_req)
		else $error("reused reset pin resets core");
endmodule : drpm_top

// ### core/drpm_cfg.svh
// offsets, field positions, reset values and timing of the pin mux
`ifndef DRPM_CFG_SVH
`define DRPM_CFG_SVH
// register byte offsets
`define DRPM_OFF_IOCFG 8'h00
`define DRPM_OFF_PUE 8'h04
`define DRPM_OFF_STAT 8'h08
// system_io_config fields
`define DRPM_BIT_RSTIO 5
`define DRPM_BIT_DBGEN 6
// port1_pullup_enable fields
`define DRPM_BIT_PU8 8
`define DRPM_BIT_PU9 9
// reset values
`define DRPM_RST_DBGEN 1'b1
`define DRPM_RST_RSTIO 1'b0
`define DRPM_RST_PUE 2'b00
`define DRPM_RST_RDATA 32'h0000_0000
// hold-off after power-on reset, in milliseconds
`define DRPM_HOLD_MS 30
// nominal low-speed oscillator rate in hertz
`define DRPM_LRC_HZ 32000
`endif

// ### core/drpm_pkg.sv
// types shared by the debug/reset pin mux
package drpm_pkg;
	// one pad: output value, output enable, pull-up enable
	typedef struct packed {
		logic out;
		logic oe;
		logic pu;
	} drpm_pad_t;
	// function of the two debug pins, one-hot
	typedef enum logic [1:0] {
		DRPM_DBG = 2'b01,
		DRPM_GPIO = 2'b10
	} drpm_mode_t;
	// hold-off counter state, oscillator domain
	typedef struct packed {
		logic [15:0] cnt;
		logic done;
	} drpm_ho_t;
	// register and synchroniser state, system domain
	typedef struct packed {
		logic dbg_en;
		logic rst_io;
		logic [1:0] pue;
		logic wp;
		logic [7:0] wa;
		logic [31:0] rdata;
		logic [2:0] done_s;
		logic done_lvl;
		logic [2:0] rpin_s;
		logic rpin_lvl;
		logic rst_req;
	} drpm_st_t;
endpackage : drpm_pkg

// ### tb/drpm_probe.sv
// debug probe model standing on the two debug pins
`timescale 1ns/1ps
module drpm_probe
	import drpm_pkg::*;
(
	// frame control and data drive from the bench
	input wire logic frame,
	input wire logic drv_oe,
	input wire logic drv_d,
	// pads of the device
	input wire drpm_pad_t p8,
	input wire drpm_pad_t p9,
	// resolved pin levels
	output logic line8,
	output logic line9
);
	logic ck = 1'b0; // probe clock, stands still between frames
	logic flt = 1'b0; // floating pin, never a steady level
	// probe clock only runs inside a frame
	always #20 if (frame) ck = ~ck;
	// an undriven pin without pull-up must not look settled
	always #5 flt = ~flt;
	// clock pin: probe only drives it, device may not
	assign line8 = p8.oe ? p8.out : frame ? ck : p8.pu ? 1'b1 : flt;
	// data pin turns round between probe and device
	assign line9 = drv_oe ? drv_d : p9.oe ? p9.out : p9.pu ? 1'b1 : flt;
endmodule : drpm_probe

// ### tb/drpm_top_tb.sv
// self-checking bench for the debug and reset pin mux
`timescale 1ns/1ps
`include "drpm_cfg.svh"
module drpm_top_tb;
	import drpm_pkg::*;
	// three oscillator periods of 80 ns, minus one for phase
	localparam time HOLD_MIN = 160;
	logic sys_clk, osc, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, gout, goe, gin;
	logic dso, dsoe, rpin, b2o, b2oe, b2in, rreq, swclk, swdi, dbgen;
	logic frame, pdo, pdoe, l8, l9;
	drpm_pad_t pad8, pad9, rpad;
	int fail_count = 0;
	int compares = 0;
	time t0;
	// ****************
	// clocks and parts
	// ****************
	initial
	begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// oscillator phase unrelated to the system clock
	initial
	begin
		osc = 0;
		#13;
		forever #40 osc = ~osc;
	end
	// small rate keeps the hold-off at three oscillator edges
	drpm_top #(.LRC_HZ(100)) drpm_top_inst (.sys_clk(sys_clk), .rst(rst),
		.low_speed_rc_osc(osc), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .port1_bit8_in(l8), .port1_bit8_pad(pad8),
		.port1_bit9_in(l9), .port1_bit9_pad(pad9), .port1_gpio_out(gout),
		.port1_gpio_oe(goe), .port1_gpio_in(gin), .dbg_swclk(swclk),
		.dbg_swdio_in(swdi), .dbg_swdio_out(dso), .dbg_swdio_oe(dsoe),
		.dbg_enable(dbgen), .external_reset_pin_in(rpin),
		.external_reset_pad(rpad), .port0_bit2_out(b2o),
		.port0_bit2_oe(b2oe), .port0_bit2_in(b2in), .ext_reset_req(rreq));
	drpm_probe drpm_probe_inst (.frame(frame), .drv_oe(pdoe), .drv_d(pdo),
		.p8(pad8), .p9(pad9), .line8(l8), .line9(l9));
	// *****
	// tasks
	// *****
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one single transfer; read data lands in rd
	task automatic ahb(input logic w, input logic [31:0] a, d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// drive an input pin just after a rising edge, look a while later
	task automatic settle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : settle
	task final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// watchdog at 20 us, whole run needs under one microsecond
	initial
	begin
		#20000;
		fail_count++;
		final_report;
	end
	// *****
	// tests
	// *****
	initial
	begin
		rst = 1; hsel = 0; haddr = 0; hwrite = 0; htrans = 0; hwdata = 0;
		gout = 0; goe = 0; dso = 0; dsoe = 0; rpin = 1; b2o = 0; b2oe = 0;
		frame = 0; pdo = 1; pdoe = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t0 = $time;
		settle(1);
		chk("dbgen", 1, dbgen);
		chk("p8oe", 0, pad8.oe);
		chk("p8pu", 1, pad8.pu);
		chk("rpad", 3'h1, rpad);
		// early reuse request is stored but held off
		ahb(1, `DRPM_OFF_IOCFG, 0);
		ahb(0, `DRPM_OFF_IOCFG, 0);
		chk("iocfg", 0, rd);
		chk("hresp", 0, hresp);
		chk("hready", 1, hreadyout);
		chk("held", 1, dbgen);
		// probe clocks and drives data while the hold-off lasts
		@(posedge sys_clk);
		frame <= 1;
		pdoe <= 1;
		pdo <= 0;
		repeat (12) @(negedge sys_clk) chk("swclk", l8, swclk);
		chk("swdi", 0, swdi);
		@(posedge sys_clk);
		pdoe <= 0;
		dsoe <= 1;
		dso <= 1;
		settle(1);
		chk("p9", 3'h7, pad9);
		@(posedge sys_clk);
		dsoe <= 0;
		frame <= 0;
		settle(1);
		chk("p9oe", 0, pad9.oe);
		// bounded wait for release; gpio use only after it
		for (int i = 0; i < 400 && dbgen !== 1'b0; i++) @(negedge sys_clk);
		chk("dbgen", 0, dbgen);
		chk("hold", 1, ($time - t0) >= HOLD_MIN);
		chk("swclk", 0, swclk);
		chk("swdi", 1, swdi);
		// status: done, reused, reset pin as reset, pin high
		ahb(0, `DRPM_OFF_STAT, 0);
		chk("stat", 32'hb, rd);
		// pull-ups from the enable register once reused
		@(posedge sys_clk);
		gout <= 2'h1;
		goe <= 2'h3;
		ahb(1, `DRPM_OFF_PUE, 32'h100);
		settle(1);
		chk("p8", 3'h7, pad8);
		chk("p9", 3'h2, pad9);
		// gpio readback follows the driven pad levels
		chk("gin", 2'h1, gin);
		ahb(1, `DRPM_OFF_PUE, 32'h200);
		settle(1);
		chk("p8", 3'h6, pad8);
		chk("p9", 3'h3, pad9);
		// writing one restores debug without a reset
		// firmware undoes reuse on request of the tool
		ahb(1, `DRPM_OFF_IOCFG, 32'h40);
		settle(1);
		chk("dbgen", 1, dbgen);
		chk("p8pu", 1, pad8.pu);
		chk("p8oe", 0, pad8.oe);
		// reset pin in its default function
		@(posedge sys_clk);
		rpin <= 0;
		settle(8);
		chk("rreq", 1, rreq);
		@(posedge sys_clk);
		rpin <= 1;
		settle(8);
		chk("rreq", 0, rreq);
		// reset pin as gpio is no reset source
		ahb(1, `DRPM_OFF_IOCFG, 32'h60);
		@(posedge sys_clk);
		rpin <= 0;
		b2o <= 1;
		b2oe <= 1;
		settle(8);
		chk("rreq", 0, rreq);
		chk("rpad", 3'h6, rpad);
		chk("b2in", 0, b2in);
		chk("dbgen", 1, dbgen);
		ahb(0, `DRPM_OFF_IOCFG, 0);
		chk("iocfg", 32'h60, rd);
		// status: done, not reused, reset pin gpio, pin low
		ahb(0, `DRPM_OFF_STAT, 0);
		chk("stat", 32'h5, rd);
		// unmapped place reads zero
		ahb(0, 32'h40, 0);
		chk("unmapped", 0, rd);
		// hard reset in mid-run brings both functions back
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		settle(1);
		chk("dbgen", 1, dbgen);
		chk("p8pu", 1, pad8.pu);
		// pin still low, so the core stays held
		settle(8);
		chk("rreq", 1, rreq);
		ahb(0, `DRPM_OFF_IOCFG, 0);
		chk("iocfg", 32'h40, rd);
		final_report;
	end
endmodule : drpm_top_tb
